//--- ram_remap_decoder_test.sv
// self-checking bench for the ram remap decoder
`timescale 1ns/1ps
`default_nettype none
module ram_remap_decoder_test;
   import rrd_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, stop, nmode, ack, hit, eon, soff, rd, wr, dir, h;
   logic [7:0]  adr, wd, rdat, q;
   logic [3:0]  sel;
   logic [31:0] dat, dout, r;
   logic [15:0] ca;
   int          mismatches, compares;
   rrd_ram_remap_decoder i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout),
      .wb_ack_o(ack), .normal_mode_i(nmode), .cpu_stop_i(stop), .cpu_addr_i(ca),
      .cpu_direct_i(dir), .cpu_rd_i(rd), .cpu_wr_i(wr), .cpu_wdata_i(wd), .cpu_rdata_o(rdat),
      .cpu_ram_hit_o(hit), .eeprom_on_bit_o(eon), .security_off_bit_o(soff));
   rrd_cpu_model i_cpu (.clk_i(clk_i), .hit_i(hit), .rdata_i(rdat), .addr_o(ca),
      .direct_o(dir), .rd_o(rd), .wr_o(wr), .wdata_o(wd));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic final_report;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (ack === 1'b1) break;
      end
      r = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n == 20) begin
         mismatches++;
         final_report();
      end
   endtask
   task automatic cpu(input logic [15:0] a, input logic d, input logic w, input logic [7:0] v,
                      input logic eh);
      i_cpu.acc(a, d, w, v, h, q);
      chk("hit", {31'h00000000, eh}, {31'h00000000, h});
   endtask
   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h1;
      dat = WB_ZERO;
      stop = 1'b0;
      nmode = 1'b1;
      mismatches = 0;
      compares = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFS_MAP, WB_ZERO);
      chk("map", 32'h00000000, r);
      bus(1'b0, OFS_CFG, WB_ZERO);
      chk("cfg", 32'h00000003, r);
      chk("cfg bits", 32'h00000003, {30'h00000000, soff, eon});
      cpu(16'h00FF, 1'b0, 1'b1, 8'h5A, 1'b1);
      cpu(16'h0100, 1'b0, 1'b0, 8'h00, 1'b0);
      cpu(16'h0000, 1'b0, 1'b0, 8'h00, 1'b1);
      bus(1'b1, OFS_MAP, 32'h00000030);
      bus(1'b0, OFS_MAP, WB_ZERO);
      chk("map", 32'h00000030, r);
      cpu(16'h3000, 1'b0, 1'b1, 8'hA5, 1'b1);
      cpu(16'h30FF, 1'b0, 1'b0, 8'h00, 1'b1);
      cpu(16'h3000, 1'b0, 1'b0, 8'h00, 1'b1);
      chk("rdata", 32'h000000A5, {24'h000000, q});
      cpu(16'h00FF, 1'b0, 1'b0, 8'h00, 1'b0);
      cpu(16'h3000, 1'b1, 1'b0, 8'h00, 1'b0);
      repeat (64) @(posedge clk_i);
      bus(1'b1, OFS_MAP, 32'h00000050);
      bus(1'b0, OFS_MAP, WB_ZERO);
      chk("map", 32'h00000030, r);
      stop <= 1'b1;
      cpu(16'h3000, 1'b0, 1'b1, 8'h11, 1'b1);
      bus(1'b1, OFS_CFG, WB_ZERO);
      bus(1'b0, OFS_CFG, WB_ZERO);
      chk("cfg", 32'h00000003, r);
      bus(1'b0, OFS_STAT, WB_ZERO);
      chk("status", 32'h00004006, r);
      stop <= 1'b0;
      cpu(16'h3000, 1'b0, 1'b0, 8'h00, 1'b1);
      chk("rdata", 32'h000000A5, {24'h000000, q});
      sel <= 4'hE;
      bus(1'b1, OFS_CFG, WB_ZERO);
      sel <= 4'h1;
      bus(1'b0, OFS_CFG, WB_ZERO);
      chk("cfg", 32'h00000003, r);
      bus(1'b1, OFS_CFG, WB_ZERO);
      bus(1'b0, 8'h0C, WB_ZERO);
      chk("unmapped", WB_ZERO, r);
      chk("cfg bits", WB_ZERO, {30'h00000000, soff, eon});
      nmode <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b0, OFS_MAP, WB_ZERO);
      chk("map", 32'h00000000, r);
      cpu(16'h0010, 1'b1, 1'b0, 8'h00, 1'b1);
      repeat (80) @(posedge clk_i);
      bus(1'b1, OFS_MAP, 32'h00000020);
      bus(1'b0, OFS_MAP, WB_ZERO);
      chk("map", 32'h00000020, r);
      cpu(16'h2000, 1'b0, 1'b0, 8'h00, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire

//--- rrd_cpu_model.sv
// cpu core bus model driving the decoder's cpu port
`timescale 1ns/1ps
`default_nettype none
module rrd_cpu_model
   import rrd_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              hit_i,
   input  wire logic [7:0]        rdata_i,
   output var logic  [ADDR_W-1:0] addr_o,
   output var logic               direct_o,
   output var logic               rd_o,
   output var logic               wr_o,
   output var logic  [7:0]        wdata_o
);
   initial begin
      addr_o = 16'hFFFF;
      direct_o = 1'b0;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'hFF;
   end
   // released address and write data show the inverse, so the stale address misses after a non-direct hit; direct_o is held, so after a direct hit it still hits
   task automatic acc(input logic [15:0] a, input logic d, input logic w,
                      input logic [7:0] wd, output logic h, output logic [7:0] q);
      @(posedge clk_i);
      addr_o <= a;
      direct_o <= d;
      rd_o <= ~w;
      wr_o <= w;
      wdata_o <= wd;
      @(posedge clk_i);
      h = hit_i;
      addr_o <= ~a;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      wdata_o <= ~wd;
      @(posedge clk_i);
      q = rdata_i;
   endtask
endmodule
`default_nettype wire

//--- rrd_pkg.sv
// constants for the relocatable on-chip ram decoder
package rrd_pkg;

   localparam int          ADDR_W        = 16;
   localparam int          PAGE_HI       = 15;
   localparam int          PAGE_LO       = 12;
   localparam int          MAP_PAGE_HI   = 7;
   localparam int          MAP_PAGE_LO   = 4;
   localparam int          DIRECT_HI     = 15;
   localparam int          DIRECT_LO     = 8;
   localparam logic [7:0]  DIRECT_BYTE   = 8'h00;
   localparam logic [3:0]  PAGE_RESET    = 4'h0;
   localparam logic [7:0]  MAP_RESET     = 8'h00;
   localparam logic [7:0]  CFG_RESET     = 8'h03;
   localparam int          WINDOW_CYCLES = 64;
   localparam int          CNT_W         = 7;
   localparam int          CFG_EEPROM_ON_BIT = 0;
   localparam int          CFG_SEC_OFF_BIT   = 1;
   localparam int          ST_WIN_BIT    = 0;
   localparam int          ST_NORM_BIT   = 1;
   localparam int          ST_STOP_BIT   = 2;
   localparam int          ST_CNT_LO     = 8;
   localparam int          WB_AW         = 8;
   localparam logic [7:0]  OFS_MAP       = 8'h00;
   localparam logic [7:0]  OFS_CFG       = 8'h04;
   localparam logic [7:0]  OFS_STAT      = 8'h08;
   localparam logic [31:0] WB_ZERO       = 32'h0000_0000;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;

endpackage

//--- rrd_ram_remap_decoder.sv
// relocatable ram decoder with mapping, config and status registers on wishbone
`timescale 1ns/1ps
`default_nettype none
module rrd_ram_remap_decoder
   import rrd_pkg::*;
#(
   parameter int RAM_AW = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [WB_AW-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire logic              normal_mode_i,
   input  wire logic              cpu_stop_i,
   input  wire logic [ADDR_W-1:0] cpu_addr_i,
   input  wire logic              cpu_direct_i,
   input  wire logic              cpu_rd_i,
   input  wire logic              cpu_wr_i,
   input  wire logic [7:0]        cpu_wdata_i,
   output logic      [7:0]        cpu_rdata_o,
   output logic                   cpu_ram_hit_o,
   output logic                   eeprom_on_bit_o,
   output logic                   security_off_bit_o
);

   localparam int RAM_DEPTH = 1 << RAM_AW;

   typedef struct packed {
      logic [RAM_DEPTH-1:0][7:0] ram;
      logic [7:0]                map;
      logic [7:0]                cfg;
      logic [CNT_W-1:0]          cnt;
      logic                      mode_s1;
      logic                      mode_s2;
      logic                      ack;
      logic [31:0]               dat;
      logic [7:0]                rdata;
   } rrd_state_t;

   rrd_state_t st;
   rrd_state_t next_st;

   // direct mode forces the high byte to zero
   function automatic logic [ADDR_W-1:0] eff_addr(input logic [ADDR_W-1:0] a,
                                                  input logic              direct);
      logic [ADDR_W-1:0] e;
      e = a;
      if (direct) begin
         e[DIRECT_HI:DIRECT_LO] = DIRECT_BYTE;
      end
      return e;
   endfunction

   // ram answers at the page base only; bits between page and index must be zero
   function automatic logic ram_hit(input logic [ADDR_W-1:0] e,
                                    input logic [3:0]        page);
      logic [ADDR_W-1:0] off;
      off = e;
      off[PAGE_HI:PAGE_LO] = PAGE_RESET;
      return (e[PAGE_HI:PAGE_LO] == page) && ((off >> RAM_AW) == '0);
   endfunction

   logic [ADDR_W-1:0] cpu_eff;
   logic [3:0]        page;
   logic              win_open;
   logic              normal;
   logic              wb_take;
   logic              wb_wr;
   logic              map_wr_ok;
   logic [RAM_AW-1:0] ram_idx;

   assign page      = st.map[MAP_PAGE_HI:MAP_PAGE_LO];
   assign cpu_eff   = eff_addr(cpu_addr_i, cpu_direct_i);
   assign ram_idx   = cpu_eff[RAM_AW-1:0];
   assign normal    = st.mode_s2;
   // counter saturates, so the window never reopens without a reset
   assign win_open  = st.cnt < CNT_W'(WINDOW_CYCLES);
   assign wb_take   = wb_cyc_i && wb_stb_i && !st.ack;
   // writes commit on the ack edge, so an aborted cycle leaves the registers alone
   assign wb_wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && st.ack;
   assign map_wr_ok = win_open || !normal;

   assign cpu_ram_hit_o      = ram_hit(cpu_eff, page);
   assign cpu_rdata_o        = st.rdata;
   assign wb_dat_o           = st.dat;
   assign wb_ack_o           = st.ack;
   assign eeprom_on_bit_o    = st.cfg[CFG_EEPROM_ON_BIT];
   assign security_off_bit_o = st.cfg[CFG_SEC_OFF_BIT];

   always_comb begin
      next_st         = st;
      next_st.mode_s1 = normal_mode_i;
      next_st.mode_s2 = st.mode_s1;
      next_st.ack     = wb_take;
      // a stopped clock is modelled by holding every stored value except bus ack, bus data and mode sync
      if (!cpu_stop_i) begin
         if (win_open) begin
            next_st.cnt = st.cnt + CNT_W'(1);
         end
         if (cpu_wr_i && cpu_ram_hit_o) begin
            next_st.ram[ram_idx] = cpu_wdata_i;
         end
         if (cpu_rd_i && cpu_ram_hit_o) begin
            next_st.rdata = st.ram[ram_idx];
         end
         if (wb_wr) begin
            if (wb_adr_i == OFS_MAP && map_wr_ok) begin
               next_st.map = wb_dat_i[7:0];
            end
            if (wb_adr_i == OFS_CFG) begin
               next_st.cfg = wb_dat_i[7:0];
            end
         end
      end
      if (wb_take) begin
         case (wb_adr_i)
            OFS_MAP: begin
               next_st.dat = {24'h000000, st.map};
            end
            OFS_CFG: begin
               next_st.dat = {24'h000000, st.cfg};
            end
            OFS_STAT: begin
               next_st.dat                              = WB_ZERO;
               next_st.dat[ST_WIN_BIT]                  = win_open;
               next_st.dat[ST_NORM_BIT]                 = normal;
               next_st.dat[ST_STOP_BIT]                 = cpu_stop_i;
               next_st.dat[ST_CNT_LO+CNT_W-1:ST_CNT_LO] = st.cnt;
            end
            default: begin
               next_st.dat = WB_ZERO;
            end
         endcase
      end
   end

   // no timeout or minimum-rate logic anywhere; state only moves on edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st         <= '0;
         st.map     <= MAP_RESET;
         st.cfg     <= CFG_RESET;
         st.mode_s1 <= 1'b1;
         st.mode_s2 <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic [7:0] wb_ram_probe;
   assign wb_ram_probe = st.ram[ram_idx];

   a_page_after_rst: assert property ($past(rst_i) |-> page == PAGE_RESET)
      else $error("page bits not zero after reset");

   a_page_drives_hit: assert property (cpu_ram_hit_o |-> cpu_eff[PAGE_HI:PAGE_LO] == page)
      else $error("ram hit outside the mapped page");

   a_default_base: assert property (page == PAGE_RESET && cpu_addr_i == '0 |-> cpu_ram_hit_o)
      else $error("ram not decoded at address zero");

   a_block_size: assert property (cpu_ram_hit_o |-> cpu_eff[PAGE_LO-1:0] < 12'(RAM_DEPTH))
      else $error("ram hit beyond the block");

   a_window_len: assert property ($past(rst_i) && !cpu_stop_i ##1 !cpu_stop_i [*7] |=> st.cnt == CNT_W'(8))
      else $error("window counter does not track cycles");

   a_late_write: assert property (normal && !win_open |=> $stable(st.map))
      else $error("mapping changed after window closed");

   a_direct_low: assert property (cpu_direct_i && cpu_ram_hit_o |-> page == PAGE_RESET)
      else $error("direct access hit a relocated ram");

   a_stop_hold: assert property (cpu_stop_i |=> $stable(st.map) && $stable(st.cfg)
                                  && $stable(st.cnt) && $stable(st.rdata))
      else $error("state changed while stopped");

   a_cfg_write: assert property (wb_wr && wb_adr_i == OFS_CFG && !cpu_stop_i
                                 |=> st.cfg == $past(wb_dat_i[7:0]))
      else $error("config byte write lost");

   a_read_data: assert property (cpu_rd_i && cpu_ram_hit_o && !cpu_stop_i
                                 |=> cpu_rdata_o == $past(wb_ram_probe))
      else $error("ram read data wrong");

   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle");

   // these watch registered state, so each one looks one edge after the cause
   a_map_rst_val: assert property ($past(rst_i) |-> st.map == MAP_RESET)
      else $error("mapping register not at reset value");

   a_cfg_rst_val: assert property ($past(rst_i) |-> st.cfg == CFG_RESET)
      else $error("config byte not at reset value");

   a_cnt_rst_val: assert property ($past(rst_i) |-> st.cnt == '0)
      else $error("window counter not cleared by reset");

   a_outs_rst_val: assert property ($past(rst_i) |-> !wb_ack_o && cpu_rdata_o == BYTE_ZERO)
      else $error("bus outputs not cleared by reset");

   a_cnt_limit: assert property (st.cnt <= CNT_W'(WINDOW_CYCLES))
      else $error("window counter ran past its limit");

   a_cnt_step: assert property (win_open && !cpu_stop_i
                                |=> st.cnt == $past(st.cnt) + CNT_W'(1))
      else $error("window counter skipped a cycle");

   a_win_shut: assert property (!win_open |=> !win_open && $stable(st.cnt))
      else $error("window reopened without a reset");

   a_early_map: assert property (wb_wr && wb_adr_i == OFS_MAP && win_open && !cpu_stop_i
                                 |=> st.map == $past(wb_dat_i[7:0]))
      else $error("mapping write inside the window lost");

   a_special_map: assert property (wb_wr && wb_adr_i == OFS_MAP && !normal && !cpu_stop_i
                                   |=> st.map == $past(wb_dat_i[7:0]))
      else $error("mapping write in special mode lost");

   a_map_hold: assert property (!wb_wr |=> $stable(st.map))
      else $error("mapping changed without a write");

   a_cfg_hold: assert property (!wb_wr |=> $stable(st.cfg))
      else $error("config byte changed without a write");

   a_nosel_ignored: assert property (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && !wb_sel_i[0]
                                     |=> $stable(st.map) && $stable(st.cfg))
      else $error("write without byte lane zero took effect");

   a_low_bits_zero: assert property (cpu_ram_hit_o |-> cpu_eff[PAGE_LO-1:RAM_AW] == '0)
      else $error("ram hit away from the page base");

   a_page_base_hit: assert property (!cpu_direct_i && cpu_addr_i[PAGE_HI:PAGE_LO] == page
                                     && cpu_addr_i[PAGE_LO-1:RAM_AW] == '0 |-> cpu_ram_hit_o)
      else $error("ram missing from its page");

   a_direct_byte: assert property (cpu_direct_i |-> cpu_eff[DIRECT_HI:DIRECT_LO] == DIRECT_BYTE)
      else $error("direct address high byte not zero");

   a_direct_page0: assert property (cpu_direct_i && page == PAGE_RESET |-> cpu_ram_hit_o)
      else $error("direct access missed ram at page zero");

   a_expanded_addr: assert property (!cpu_direct_i |-> cpu_eff == cpu_addr_i)
      else $error("expanded address altered");

   a_ram_write: assert property (cpu_wr_i && cpu_ram_hit_o && !cpu_stop_i
                                 |=> st.ram[$past(ram_idx)] == $past(cpu_wdata_i))
      else $error("ram write lost");

   a_miss_no_write: assert property (!cpu_ram_hit_o |=> $stable(st.ram))
      else $error("ram changed by an access outside the block");

   a_ram_stop: assert property (cpu_stop_i |=> $stable(st.ram))
      else $error("ram changed while stopped");

   a_rd_hold: assert property (!(cpu_rd_i && cpu_ram_hit_o && !cpu_stop_i) |=> $stable(cpu_rdata_o))
      else $error("ram read data changed without a read");

   a_stat_stop: assert property (wb_take && wb_adr_i == OFS_STAT
                                 |=> wb_dat_o[ST_STOP_BIT] == $past(cpu_stop_i))
      else $error("status does not show the stop state");

   a_stat_window: assert property (wb_take && wb_adr_i == OFS_STAT
                                   |=> wb_dat_o[ST_WIN_BIT] == $past(win_open))
      else $error("status does not show the window state");

   a_unmapped_read: assert property (wb_take && wb_adr_i != OFS_MAP && wb_adr_i != OFS_CFG
                                     && wb_adr_i != OFS_STAT |=> wb_dat_o == WB_ZERO)
      else $error("unmapped register read not zero");

   a_dat_hold: assert property (!wb_take |=> $stable(wb_dat_o))
      else $error("read data changed without a request");

   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("bus ack without a request");

   a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held for two cycles");

   a_cfg_pins: assert property ($past(wb_wr && wb_adr_i == OFS_CFG && !cpu_stop_i)
                                |-> eeprom_on_bit_o == $past(wb_dat_i[CFG_EEPROM_ON_BIT])
                                && security_off_bit_o == $past(wb_dat_i[CFG_SEC_OFF_BIT]))
      else $error("config pins do not follow the written byte");

   c_relocate: cover property (win_open ##1 page != PAGE_RESET);
   c_late_refused: cover property (normal && !win_open && wb_wr && wb_adr_i == OFS_MAP);
   c_special_write: cover property (!normal && wb_wr && wb_adr_i == OFS_MAP);
   c_stop: cover property (cpu_stop_i [*3] ##1 !cpu_stop_i);
   c_direct: cover property (cpu_direct_i && cpu_ram_hit_o && cpu_rd_i);

endmodule
`default_nettype wire
